// ==== acc_top.v ====
// Converter control: registers, prescaler, sequencer, result pair
// Assumes an AXI4-Lite master and an analog core whose sample is valid
// by the last converter clock of a conversion
//
// What this block does
// - Codes 0-7 single inputs, 1E bandgap, 1F ground
// - Codes 08-1D pick differential pair and gain
// - Selection change waits for conversion end
// - On bit powers converter, clearing aborts conversion
// - Free running: one start, then automatic
// - First conversion 25 clocks, others 13
// - Start bit reads busy; zero write ignored
// - Auto trigger starts on selected rising edge
// - Flag sets at conversion end, even while the pair is frozen
// - Interrupt request needs flag, enable, global enable
// - Vector acknowledge clears the flag
// - Writing one clears flag, zero keeps
// - Prescaler divides by 2,2,4..128
// - Right aligned result at 4 and 5
// - Low read freezes pair until high read
// - Left align bit repositions result immediately
// - Switching to free running is no trigger
// - Differential results two's complement 200-1FF
`timescale 1ns/1ps
`include "acc_map.vh"
module acc_top (
  // Clock and reset
  input  wire        CORE_CLK,
  input  wire        RST,
  // AXI4-Lite slave
  input  wire [5:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [5:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  // Processor side
  input  wire        GLOBAL_IRQ_ON,
  input  wire        IRQ_ACK,
  input  wire [7:1]  TRIG_SRC_IN,
  output reg         COMPLETE_IRQ,
  // Analog front end
  output reg  [4:0]  CHANNEL_GAIN_SELECT,
  output reg         CONVERTER_POWER,
  output reg         SAMPLE_STROBE,
  input  wire [9:0]  CORE_RESULT
);
  localparam ST_IDLE = 2'b01;
  localparam ST_CONV = 2'b10;

  reg  [7:0]  ctrl_ff;
  reg  [7:0]  insel_ff;
  reg  [2:0]  tsrc_ff;
  reg  [9:0]  res_ff;
  reg         frozen_ff;
  reg  [9:0]  hold_ff;
  reg  [1:0]  st_ff;
  reg  [4:0]  cyc_ff;
  reg         first_ff;
  reg  [6:0]  div_ff;
  reg         trig_q_ff;
  reg  [5:0]  aw_ff;
  reg         awv_ff;
  reg  [31:0] wd_ff;
  reg  [3:0]  ws_ff;
  reg         wv_ff;
  reg  [4:0]  sel_run_ff;

  wire        do_wr = awv_ff && wv_ff && !S_AXI_BVALID;
  wire [3:0]  wr_idx = aw_ff[5:2];
  wire        wr_ctl = do_wr && wr_idx == `ACC_IDX_CTRL && ws_ff[0];
  wire        wr_sel = do_wr && wr_idx == `ACC_IDX_INSEL && ws_ff[0];
  wire        wr_tsb = do_wr && wr_idx == `ACC_IDX_CTRL_B && ws_ff[0];
  wire        rd_go  = S_AXI_ARVALID && S_AXI_ARREADY;
  wire [3:0]  rd_idx = S_AXI_ARADDR[5:2];
  wire        on     = ctrl_ff[`ACC_B_ON];
  wire        busy   = st_ff == ST_CONV;
  // Enable as it stands after this edge, so an enabling start keeps busy
  wire        nxt_on = wr_ctl ? wd_ff[`ACC_B_ON] : on;

  // Prescaler: code 0 and 1 both divide by two
  reg  [6:0]  div_mask;
  always @* begin
    case (ctrl_ff[2:0])
      3'h0, 3'h1: div_mask = 7'h01;
      3'h2: div_mask = 7'h03;
      3'h3: div_mask = 7'h07;
      3'h4: div_mask = 7'h0f;
      3'h5: div_mask = 7'h1f;
      3'h6: div_mask = 7'h3f;
      default: div_mask = 7'h7f;
    endcase
  end
  wire tick = on && ((div_ff & div_mask) == div_mask);

  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      div_ff <= 7'h00;
    end else if (!on) begin
      div_ff <= 7'h00;
    end else begin
      div_ff <= div_ff + 7'h01;
    end
  end

  // Trigger source: 0 is free running, which reuses the flag
  wire [7:0] trig_all  = {TRIG_SRC_IN, ctrl_ff[`ACC_B_FLAG]};
  wire       trig_sel  = trig_all[tsrc_ff];
  wire       trig_edge = trig_sel && !trig_q_ff;
  wire auto_go = ctrl_ff[`ACC_B_AUTO] && trig_edge && on;

  wire sw_start = wr_ctl && wd_ff[`ACC_B_START] && wd_ff[`ACC_B_ON];
  wire done = busy && tick && cyc_ff == 5'h01;
  wire launch = !busy && (sw_start || auto_go || ctrl_ff[`ACC_B_START]
                && on);

  // Sequencer
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      st_ff      <= ST_IDLE;
      cyc_ff     <= 5'h00;
      first_ff   <= 1'b1;
      sel_run_ff <= 5'h00;
    end else begin
      // Launch below overrides, so an enabling start counts as first
      if (!on) begin
        first_ff <= 1'b1;
      end
      case (st_ff)
        ST_IDLE: begin
          if (launch) begin
            st_ff      <= ST_CONV;
            cyc_ff     <= first_ff ? `ACC_FIRST_CYC : `ACC_NORM_CYC;
            first_ff   <= 1'b0;
            sel_run_ff <= insel_ff[4:0];
          end
        end
        ST_CONV: begin
          if (!on) begin
            st_ff <= ST_IDLE;
          end else if (tick) begin
            cyc_ff <= cyc_ff - 5'h01;
            if (cyc_ff == 5'h01) begin
              st_ff <= ST_IDLE;
            end
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // Control/status register
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl_ff   <= 8'h00;
      insel_ff  <= 8'h00;
      tsrc_ff   <= 3'h0;
      trig_q_ff <= 1'b0;
    end else begin
      // Switching to free running reloads history, so no edge appears
      if (wr_tsb && wd_ff[2:0] == `ACC_TRIG_FREE) begin
        trig_q_ff <= ctrl_ff[`ACC_B_FLAG];
      end else begin
        trig_q_ff <= trig_sel;
      end
      if (wr_ctl) begin
        ctrl_ff[`ACC_B_ON]   <= wd_ff[`ACC_B_ON];
        ctrl_ff[`ACC_B_AUTO] <= wd_ff[`ACC_B_AUTO];
        ctrl_ff[`ACC_B_IE]   <= wd_ff[`ACC_B_IE];
        ctrl_ff[2:0]         <= wd_ff[2:0];
      end
      if (wr_sel) begin
        insel_ff <= wd_ff[7:0];
      end
      if (wr_tsb) begin
        tsrc_ff <= wd_ff[2:0];
      end
      // Start bit: set by software one, cleared at end or abort
      if (done || !nxt_on) begin
        ctrl_ff[`ACC_B_START] <= 1'b0;
      end else if ((wr_ctl && wd_ff[`ACC_B_START]) || launch) begin
        ctrl_ff[`ACC_B_START] <= 1'b1;
      end
      // Completion set wins over both clears
      if (done) begin
        ctrl_ff[`ACC_B_FLAG] <= 1'b1;
      end else if (IRQ_ACK || (wr_ctl && wd_ff[`ACC_B_FLAG])) begin
        ctrl_ff[`ACC_B_FLAG] <= 1'b0;
      end
    end
  end

  // Result pair; reading low freezes it until high is read
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      res_ff    <= 10'h000;
      hold_ff   <= 10'h000;
      frozen_ff <= 1'b0;
    end else begin
      if (done) begin
        hold_ff <= CORE_RESULT;
      end
      if (rd_go && rd_idx == `ACC_IDX_RES_LO) begin
        frozen_ff <= 1'b1;
      end else if (rd_go && rd_idx == `ACC_IDX_RES_HI) begin
        frozen_ff <= 1'b0;
      end
      if (done && !frozen_ff) begin
        res_ff <= CORE_RESULT;
      end else if (!frozen_ff && !done) begin
        res_ff <= hold_ff;
      end
    end
  end

  // Alignment applies at read time, so a change shows at once
  wire left = insel_ff[`ACC_B_LEFT];
  wire [7:0] lo_v = left ? {res_ff[1:0], 6'h00} : res_ff[7:0];
  wire [7:0] hi_v = left ? res_ff[9:2] : {6'h00, res_ff[9:8]};

  reg [7:0] rd_v;
  reg       rd_ok;
  always @* begin
    rd_ok = 1'b1;
    case (rd_idx)
      `ACC_IDX_RES_LO: rd_v = lo_v;
      `ACC_IDX_RES_HI: rd_v = hi_v;
      `ACC_IDX_CTRL:   rd_v = ctrl_ff;
      `ACC_IDX_INSEL:  rd_v = insel_ff;
      `ACC_IDX_CTRL_B: rd_v = {5'h00, tsrc_ff};
      default: begin
        rd_v  = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  // AXI write: address and data latched in either order
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `ACC_RESP_OKAY;
      aw_ff         <= 6'h00;
      awv_ff        <= 1'b0;
      wd_ff         <= 32'h00000000;
      ws_ff         <= 4'h0;
      wv_ff         <= 1'b0;
    end else begin
      S_AXI_AWREADY <= !awv_ff && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY  <= !wv_ff && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_ff  <= S_AXI_AWADDR;
        awv_ff <= 1'b1;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        wd_ff  <= S_AXI_WDATA;
        ws_ff  <= S_AXI_WSTRB;
        wv_ff  <= 1'b1;
      end
      if (do_wr) begin
        awv_ff       <= 1'b0;
        wv_ff        <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (wr_idx == `ACC_IDX_CTRL || wr_idx == `ACC_IDX_INSEL
                        || wr_idx == `ACC_IDX_CTRL_B
                        || wr_idx == `ACC_IDX_RES_LO
                        || wr_idx == `ACC_IDX_RES_HI)
                        ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // AXI read
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `ACC_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
      if (rd_go) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= {24'h000000, rd_v};
        S_AXI_RRESP  <= rd_ok ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // Outputs; selection follows the register when idle and is held from launch, so mid-run writes wait
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      COMPLETE_IRQ        <= 1'b0;
      CHANNEL_GAIN_SELECT <= 5'h00;
      CONVERTER_POWER     <= 1'b0;
      SAMPLE_STROBE       <= 1'b0;
    end else begin
      COMPLETE_IRQ <= ctrl_ff[`ACC_B_FLAG] && ctrl_ff[`ACC_B_IE]
                      && GLOBAL_IRQ_ON;
      CHANNEL_GAIN_SELECT <= busy ? sel_run_ff : insel_ff[4:0];
      CONVERTER_POWER     <= nxt_on;
      SAMPLE_STROBE       <= launch;
    end
  end
endmodule // acc_top

// ==== acc_map.vh ====
// Register map, field positions and timing counts for the converter control
// Assumes an AXI4-Lite slave with 32-bit data, one register per word
`ifndef ACC_MAP_VH
`define ACC_MAP_VH
// Printed offsets are not multiples of four: they are indices
`define ACC_IDX_RES_LO   4'h4
`define ACC_IDX_RES_HI   4'h5
`define ACC_IDX_CTRL     4'h6
`define ACC_IDX_INSEL    4'h7
`define ACC_IDX_CTRL_B   4'h8
// Control/status fields
`define ACC_B_ON         7
`define ACC_B_START      6
`define ACC_B_AUTO       5
`define ACC_B_FLAG       4
`define ACC_B_IE         3
// Input selection fields
`define ACC_B_LEFT       5
// Cycle counts in converter clocks, then selection, trigger and response codes
`define ACC_FIRST_CYC    5'h19
`define ACC_NORM_CYC     5'h0d
`define ACC_SEL_BG       5'h1e
`define ACC_SEL_GND      5'h1f
`define ACC_SEL_DIFF_LO  5'h08
`define ACC_TRIG_FREE    3'h0
`define ACC_RESP_OKAY    2'h0
`define ACC_RESP_SLVERR  2'h2
`endif

// ==== acc_core_model.sv ====
// Stand-in for the analog mux, gain stage and converter core
// Assumes one sample strobe per conversion and a held selection
`timescale 1ns/1ps
module acc_core_model (
  // Clock
  input  wire       clk,
  // Core side
  input  wire       strobe,
  input  wire [4:0] sel,
  output reg  [9:0] result
);
  // Code repeats the selection, so a wrong route shows in the result
  initial result = 10'h000;
  always @(posedge clk) if (strobe) result <= {sel, sel};
endmodule // acc_core_model

// ==== acc_top_checker.sv ====
// Port-level checks for the converter control
// Assumes binding to acc_top, one clock domain
`timescale 1ns/1ps
module acc_top_checker (
  // Clock and reset
  input wire        CORE_CLK,
  input wire        RST,
  // Read channel
  input wire        S_AXI_RVALID,
  input wire        S_AXI_RREADY,
  input wire [31:0] S_AXI_RDATA,
  // Core side
  input wire        GLOBAL_IRQ_ON,
  input wire        IRQ_ACK,
  input wire        COMPLETE_IRQ,
  input wire        CONVERTER_POWER,
  input wire        SAMPLE_STROBE,
  input wire [4:0]  CHANNEL_GAIN_SELECT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  sequence launch; SAMPLE_STROBE; endsequence
  // Power loss aborts, so the selection may move then
  sequence sel_held;
    ($stable(CHANNEL_GAIN_SELECT) || !CONVERTER_POWER)[*8];
  endsequence
  a_sel_held: assert property (launch |=> sel_held)
    else $error("selection moved during conversion");
  a_strobe_pulse: assert property (launch |=> (!SAMPLE_STROBE)[*8])
    else $error("sample strobe too close");
  a_off_no_start: assert property ((!CONVERTER_POWER)[*3] |->
    !SAMPLE_STROBE)
    else $error("strobe while powered down");
  a_irq_needs_gie: assert property (COMPLETE_IRQ |-> $past(GLOBAL_IRQ_ON))
    else $error("interrupt without global enable");
  a_gie_off_quiet: assert property (!GLOBAL_IRQ_ON |=> !COMPLETE_IRQ)
    else $error("interrupt after global disable");
  a_ack_clears: assert property (COMPLETE_IRQ && IRQ_ACK |=>
    ##[0:1] !COMPLETE_IRQ)
    else $error("acknowledge left interrupt up");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer dropped or changed");
  a_upper_zero: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
    else $error("upper read bits not zero");
endmodule // acc_top_checker

bind acc_top acc_top_checker i_chk (.CORE_CLK(CORE_CLK), .RST(RST),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .GLOBAL_IRQ_ON(GLOBAL_IRQ_ON),
  .IRQ_ACK(IRQ_ACK), .COMPLETE_IRQ(COMPLETE_IRQ),
  .CONVERTER_POWER(CONVERTER_POWER), .SAMPLE_STROBE(SAMPLE_STROBE),
  .CHANNEL_GAIN_SELECT(CHANNEL_GAIN_SELECT));

// ==== test_analog_converter_control.sv ====
// Self-checking bench for the converter control over AXI4-Lite
// Assumes acc_top, acc_core_model and the bound checker
`timescale 1ns/1ps
module test_analog_converter_control;
  logic clk, rst, awv, wv, bready, arv, rready, gie, ack;
  logic [5:0] awa, ara;
  logic [31:0] wd, d;
  logic [7:1] trig;
  logic [1:0] lresp, lbresp;
  wire awr, wrdy, bvalid, arr, rvalid, irq, pwr, stb;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [4:0] sel;
  wire [9:0] res;
  int error_cnt, cmp_count, since, p;
  acc_top i_acc_top (.CORE_CLK(clk), .RST(rst), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .GLOBAL_IRQ_ON(gie), .IRQ_ACK(ack),
    .TRIG_SRC_IN(trig), .COMPLETE_IRQ(irq), .CHANNEL_GAIN_SELECT(sel),
    .CONVERTER_POWER(pwr), .SAMPLE_STROBE(stb), .CORE_RESULT(res));
  acc_core_model i_acc_core_model (.clk(clk), .strobe(stb), .sel(sel),
    .result(res));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  // Cycles since the last launch, for conversion length
  always @(posedge clk) since <= stb ? 0 : since + 1;
  task automatic wr(input [5:0] a, input [7:0] v);
    @(posedge clk);
    awa <= a; wd <= {24'h000000, v}; awv <= 1; wv <= 1; bready <= 1;
    fork
      begin do @(posedge clk); while (!awr); awv <= 0; end
      begin do @(posedge clk); while (!wrdy); wv <= 0; end
    join
    while (!bvalid) @(posedge clk);
    lbresp = bresp;
    bready <= 0;
  endtask
  task automatic rd(input [5:0] a);
    @(posedge clk);
    ara <= a; arv <= 1;
    do @(posedge clk); while (!arr);
    arv <= 0;
    while (!rvalid) @(posedge clk);
    rready <= 1;
    @(posedge clk);
    d = rdata; lresp = rresp; rready <= 0;
  endtask
  task automatic chk(input [31:0] seen, exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conv(input [7:0] c, input int t, dv);
    wr(6'h18, c);
    rd(6'h18); chk(d[6], 1'b1, "busy");
    while (!irq) @(posedge clk);
    chk(since >= t*dv - dv && since <= t*dv + dv + 4, 1, "length");
    wr(6'h18, 8'h98);
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    rst = 1; awv = 0; wv = 0; bready = 0; arv = 0; rready = 0; gie = 1;
    ack = 0; awa = 0; ara = 0; wd = 0; trig = 0;
    repeat (20) @(posedge clk);
    rst <= 0;
    rd(6'h10); chk(d, 0, "res_lo rst");
    rd(6'h14); chk(d, 0, "res_hi rst");
    rd(6'h18); chk(d, 0, "ctrl rst");
    rd(6'h3c); chk(lresp, 2'h2, "unmapped");
    wr(6'h3c, 8'h00);
    chk(lbresp, 2'h2, "wr unmapped");
    wr(6'h1c, 8'h0d);
    chk(lbresp, 2'h0, "wr okay");
    conv(8'hc8, 25, 2);
    rd(6'h10); chk(d, 8'had, "res_lo");
    rd(6'h14); chk(d, 8'h01, "res_hi");
    rd(6'h18); chk(d, 8'h88, "ctrl idle");
    chk(pwr, 1'b1, "power on");
    wr(6'h1c, 8'h2d);
    rd(6'h10); chk(d, 8'h40, "left lo");
    rd(6'h14); chk(d, 8'h6b, "left hi");
    for (p = 0; p < 8; p++) conv(8'hc8 | p, 13, p == 0 ? 2 : 1 << p);
    wr(6'h18, 8'hcf);
    wr(6'h1c, 8'h1e);
    chk(sel, 5'h0d, "sel held");
    while (!irq) @(posedge clk);
    wr(6'h18, 8'h98);
    conv(8'hc8, 13, 2);
    rd(6'h10); chk(d, 8'hde, "bandgap lo");
    // Pair stays frozen from the bandgap low read; new result waits
    wr(6'h1c, 8'h05);
    wr(6'h18, 8'hc8);
    while (!irq) @(posedge clk);
    gie <= 0;
    repeat (2) @(posedge clk);
    chk(irq, 1'b0, "gie off");
    gie <= 1;
    repeat (2) @(posedge clk);
    chk(irq, 1'b1, "irq");
    wr(6'h18, 8'h88);
    rd(6'h18);
    chk(d, 8'h98, "zero keeps flag");
    ack <= 1;
    @(posedge clk);
    ack <= 0;
    rd(6'h18); chk(d, 8'h88, "ack clear");
    rd(6'h14);
    chk(d, 8'h03, "frozen hi");
    rd(6'h10);
    chk(d, 8'ha5, "fresh lo");
    wr(6'h20, 8'h01);
    wr(6'h18, 8'hb8);
    trig[1] <= 1;
    while (!irq) @(posedge clk);
    chk(since < 60, 1, "trigger");
    trig[1] <= 0;
    // Flag is still set here, so a false edge would relaunch at once
    wr(6'h20, 8'h00);
    repeat (4) @(posedge clk);
    chk(since > 20, 1, "free switch");
    wr(6'h18, 8'hf8);
    repeat (2) @(posedge clk);
    while (!irq) @(posedge clk);
    ack <= 1;
    @(posedge clk);
    ack <= 0;
    repeat (2) @(posedge clk);
    for (p = 0; p < 60 && !irq; p++) @(posedge clk);
    chk(irq && since <= 32, 1, "free run");
    wr(6'h18, 8'h18);
    chk(pwr, 1'b0, "power off");
    rd(6'h18);
    chk(d, 8'h08, "abort ctrl");
    repeat (60) @(posedge clk);
    chk(irq, 1'b0, "abort no done");
    wrap_up;
  end
  initial begin
    #400000;
    error_cnt++;
    wrap_up;
  end
endmodule // test_analog_converter_control
